// File: hw/srap_regs.svh
// Timing counts and reset levels for the slave register access port.
// Assumes a single 125 MHz clock that also serves as the bus clock.
`ifndef SRAP_REGS_SVH
`define SRAP_REGS_SVH

// Bus clock period in ns
`define SRAP_CLK_PERIOD_NS 8
// Acknowledge delay in bus clocks, idle core
`define SRAP_ACK_DLY_IDLE 3'h1
// Acknowledge delay in bus clocks, core busy
`define SRAP_ACK_DLY_BUSY 3'h5
// Width of the acknowledge delay counter
`define SRAP_CNT_W 3
// Synchroniser depth for pin inputs
`define SRAP_SYNC_STAGES 2
// Idle level of the memory acknowledge
`define SRAP_SLAVE_MEM_ACK_IDLE 1'h1
// Driven-high level of the data-size acknowledge pair
`define SRAP_DSACK_HIGH 2'h3
// Asserted level of the data-size acknowledge pair
`define SRAP_DSACK_LOW 2'h0

`endif

// File: hw/srap_pkg.sv
// Types shared by the slave register access port.
// Assumes nothing beyond a SystemVerilog compiler.
package srap_pkg;

    parameter int ADDR_W = 6;

    typedef logic [ADDR_W-1:0] srap_addr_t;

    typedef struct packed {
        srap_addr_t addr;
        logic write;
    } srap_acc_s;

    typedef enum logic [2:0] {
        S_IDLE,
        S_WAIT,
        S_SEL,
        S_ACK,
        S_RELEASE,
        S_MISS,
        S_MISS_LOW
    } srap_state_e;

endpackage

// File: hw/srap_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to sys_clk.
`timescale 1ns/1ns
module srap_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta;

    // Only the second stage is read outside this module
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RST;
            dout <= RST;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

// File: hw/srap_port.sv
// Slave register access port, big-endian bus mode, device side.
// Assumes chip select, strobe, direction and address come from pins,
// and core_busy, master_active, master_wait from logic on sys_clk.
`timescale 1ns/1ns
`include "srap_regs.svh"
module srap_port #(
    parameter logic [`SRAP_CNT_W-1:0] ACK_DLY_IDLE = `SRAP_ACK_DLY_IDLE,
    parameter logic [`SRAP_CNT_W-1:0] ACK_DLY_BUSY = `SRAP_ACK_DLY_BUSY
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic slave_addr_strobe_n,
    input wire logic slave_read_write,
    input wire srap_pkg::srap_addr_t reg_addr_pin,
    input wire logic core_busy,
    input wire logic master_active,
    input wire logic master_wait,
    output logic slave_mem_ack_n,
    output logic [1:0] data_size_ack_pair_out,
    output logic data_size_ack_pair_oe,
    output logic reg_req,
    output srap_pkg::srap_acc_s reg_req_acc,
    output srap_pkg::srap_acc_s reg_latched_acc
);

    localparam int SW = srap_pkg::ADDR_W + 3;
    localparam logic [SW-1:0] SYNC_RST = {2'h3, {(SW - 2){1'b0}}};

    logic [SW-1:0] pin_s;
    logic cs_s;
    logic sas_s;
    logic rw_s;
    srap_pkg::srap_addr_t addr_s;
    logic sas_q;
    logic stall;
    srap_pkg::srap_acc_s acc_now;
    srap_pkg::srap_acc_s acc_hold;
    srap_pkg::srap_state_e state;
    logic [`SRAP_CNT_W-1:0] cnt;

    // no setup needed
    // Address and direction share the stages so they stay aligned
    srap_sync #(
        .W(SW),
        .RST(SYNC_RST)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .din({cs_n, slave_addr_strobe_n, slave_read_write, reg_addr_pin}),
        .dout(pin_s)
    );

    assign cs_s = pin_s[SW-1];
    assign sas_s = pin_s[SW-2];
    assign rw_s = pin_s[SW-3];
    assign addr_s = pin_s[srap_pkg::ADDR_W-1:0];
    assign acc_now = '{addr: addr_s, write: ~rw_s};

    assign stall = master_active & master_wait;

    // Strobe history for rising-edge detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sas_q <= 1'b1;
        end else begin
            sas_q <= sas_s;
        end
    end

    // Track address while strobe is low; pins only hold briefly after
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_hold <= '0;
        end else if (!sas_s) begin
            acc_hold <= acc_now;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_latched_acc <= '0;
        end else if (sas_s && !sas_q) begin
            reg_latched_acc <= acc_hold;
        end
    end

    // Slave access sequencing and acknowledge pins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= srap_pkg::S_IDLE;
            cnt <= '0;
            slave_mem_ack_n <= `SRAP_SLAVE_MEM_ACK_IDLE;
            data_size_ack_pair_out <= `SRAP_DSACK_HIGH;
            data_size_ack_pair_oe <= 1'b0;
            reg_req <= 1'b0;
            reg_req_acc <= '0;
        end else begin
            reg_req <= 1'b0;
            unique case (state)
                srap_pkg::S_IDLE: begin
                    if (!cs_s) begin
                        if (!sas_s) begin
                            state <= srap_pkg::S_WAIT;
                            cnt <= core_busy ? ACK_DLY_BUSY - 3'h1
                                             : ACK_DLY_IDLE - 3'h1;
                        end else begin
                            state <= srap_pkg::S_MISS;
                        end
                    end
                end
                srap_pkg::S_WAIT: begin
                    if (cs_s) begin
                        state <= srap_pkg::S_IDLE;
                    end else if (sas_s) begin
                        state <= srap_pkg::S_SEL;
                    end else if (!stall) begin
                        if (cnt == '0) begin
                            slave_mem_ack_n <= 1'b0;
                            data_size_ack_pair_out <= `SRAP_DSACK_LOW;
                            data_size_ack_pair_oe <= 1'b1;
                            reg_req <= 1'b1;
                            reg_req_acc <= acc_now;
                            state <= srap_pkg::S_ACK;
                        end else begin
                            cnt <= cnt - 3'h1;
                        end
                    end
                end
                srap_pkg::S_SEL: begin
                    if (cs_s) begin
                        state <= srap_pkg::S_IDLE;
                    end else if (!sas_s) begin
                        slave_mem_ack_n <= 1'b0;
                        data_size_ack_pair_out <= `SRAP_DSACK_LOW;
                        data_size_ack_pair_oe <= 1'b1;
                        reg_req <= 1'b1;
                        reg_req_acc <= acc_now;
                        state <= srap_pkg::S_ACK;
                    end
                end
                srap_pkg::S_ACK: begin
                    if (sas_s) begin
                        slave_mem_ack_n <= 1'b1;
                        data_size_ack_pair_out <= `SRAP_DSACK_HIGH;
                        data_size_ack_pair_oe <= 1'b0;
                        state <= cs_s ? srap_pkg::S_IDLE : srap_pkg::S_SEL;
                    end else if (cs_s) begin
                        slave_mem_ack_n <= 1'b1;
                        data_size_ack_pair_out <= `SRAP_DSACK_HIGH;
                        state <= srap_pkg::S_RELEASE;
                    end
                end
                srap_pkg::S_RELEASE: begin
                    // Only the strobe may let the pair float
                    if (sas_s) begin
                        data_size_ack_pair_oe <= 1'b0;
                        state <= srap_pkg::S_IDLE;
                    end
                end
                srap_pkg::S_MISS: begin
                    if (cs_s) begin
                        state <= srap_pkg::S_IDLE;
                    end else if (!sas_s) begin
                        state <= srap_pkg::S_MISS_LOW;
                    end
                end
                srap_pkg::S_MISS_LOW: begin
                    if (cs_s) begin
                        state <= srap_pkg::S_IDLE;
                    end else if (sas_s) begin
                        state <= srap_pkg::S_SEL;
                    end
                end
                default: begin
                    state <= srap_pkg::S_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence start_idle_s;
        state == srap_pkg::S_IDLE && !cs_s && !sas_s && !core_busy;
    endsequence

    sequence start_busy_s;
        state == srap_pkg::S_IDLE && !cs_s && !sas_s && core_busy;
    endsequence

    sequence hold_sel_s;
        !cs_s && !sas_s && !stall;
    endsequence

    ack_idle_delay_a:
    assert property (start_idle_s ##1 hold_sel_s |=> !slave_mem_ack_n)
        else $error("ack not one clock after idle select");

    ack_busy_delay_a:
    assert property (start_busy_s ##1 hold_sel_s [*5]
        |-> $past(slave_mem_ack_n) ##1 !slave_mem_ack_n)
        else $error("busy ack delay is not five clocks");

    ack_busy_early_a:
    assert property (start_busy_s |=> slave_mem_ack_n [*5])
        else $error("busy ack came too early");

    master_stall_a:
    assert property (state == srap_pkg::S_WAIT && stall && !cs_s && !sas_s
        |=> slave_mem_ack_n && state == srap_pkg::S_WAIT && $stable(cnt))
        else $error("ack delay not stretched by wait state");

    held_select_ack_a:
    assert property (state == srap_pkg::S_SEL && !cs_s && !sas_s
        |=> !slave_mem_ack_n && reg_req)
        else $error("held select did not ack on strobe");

    next_access_a:
    assert property (state == srap_pkg::S_ACK && sas_s && !cs_s
        |=> state == srap_pkg::S_SEL)
        else $error("strobe release did not end access");

    pair_low_a:
    assert property (!slave_mem_ack_n
        |-> data_size_ack_pair_oe && data_size_ack_pair_out == 2'h0)
        else $error("pair not driven low with ack");

    cs_drive_high_a:
    assert property (state == srap_pkg::S_ACK && cs_s && !sas_s
        |=> data_size_ack_pair_oe && data_size_ack_pair_out == 2'h3)
        else $error("select release did not drive pair high");

    sas_float_a:
    assert property ((state == srap_pkg::S_ACK
        || state == srap_pkg::S_RELEASE) && sas_s
        |=> !data_size_ack_pair_oe && slave_mem_ack_n)
        else $error("strobe release did not float pair");

    addr_capture_a:
    assert property (sas_s && !sas_q |=> reg_latched_acc == $past(acc_now, 2))
        else $error("address not captured on strobe rise");

    miss_hold_a:
    assert property (state == srap_pkg::S_MISS_LOW |=> slave_mem_ack_n)
        else $error("ack given before late strobe released");

    ack_needs_sas_a:
    assert property (!slave_mem_ack_n |-> !$past(sas_s))
        else $error("ack low while strobe high");

    countdown_step_a:
    assert property (state == srap_pkg::S_WAIT && !cs_s && !sas_s && !stall
        && cnt != 3'h0 |=> cnt == $past(cnt) - 3'h1)
        else $error("ack countdown did not step");

    req_one_pulse_a:
    assert property (reg_req |=> !reg_req)
        else $error("request pulse longer than one clock");

    miss_no_ack_a:
    assert property (state == srap_pkg::S_MISS |=> slave_mem_ack_n)
        else $error("ack given to a missed strobe");

    wait_abort_a:
    assert property (state == srap_pkg::S_WAIT && (cs_s || sas_s)
        |=> slave_mem_ack_n && !reg_req)
        else $error("ack given after select or strobe left");

    idle_released_a:
    assert property (state == srap_pkg::S_IDLE
        |-> slave_mem_ack_n && !data_size_ack_pair_oe)
        else $error("pair still driven in idle");

endmodule

// File: tb/srap_host.sv
// Host bus master model driving the slave port pins.
// Assumes the bench calls its tasks from the sys_clk domain.
`timescale 1ns/1ns
module srap_host (
    input wire logic sys_clk,
    output logic cs_n,
    output logic slave_addr_strobe_n,
    output logic slave_read_write,
    output srap_pkg::srap_addr_t reg_addr_pin
);
    initial begin
        cs_n = 1'h1;
        slave_addr_strobe_n = 1'h1;
        slave_read_write = 1'h1;
        reg_addr_pin = '0;
    end
    // strobe with select
    // Pins move just after a rising edge only
    task automatic drive(input logic cs, input logic as, input logic rw,
                         input srap_pkg::srap_addr_t a);
        @(posedge sys_clk);
        cs_n <= cs;
        slave_addr_strobe_n <= as;
        slave_read_write <= rw;
        reg_addr_pin <= a;
    endtask
    task automatic drop_cs();
        @(posedge sys_clk);
        cs_n <= 1'h1;
    endtask
    task automatic finish(input logic keep);
        @(posedge sys_clk);
        slave_addr_strobe_n <= 1'h1;
        cs_n <= ~keep;
    endtask
    // Released lines do not keep the old value
    task automatic scramble();
        @(posedge sys_clk);
        slave_read_write <= ~slave_read_write;
        reg_addr_pin <= ~reg_addr_pin;
    endtask
endmodule

// File: tb/srap_port_tb.sv
// Self-checking bench for the slave register access port.
// Assumes the host model in srap_host.sv drives the pins.
`timescale 1ns/1ns
module slave_register_access_port_tb;
    logic sys_clk;
    logic rst_n;
    logic cs_n;
    logic strobe_n;
    logic rw;
    srap_pkg::srap_addr_t addr;
    logic core_busy;
    logic master_active;
    logic master_wait;
    logic slave_mem_ack_n;
    logic [1:0] pair;
    logic oe;
    logic reg_req;
    srap_pkg::srap_acc_s req_acc;
    srap_pkg::srap_acc_s lat_acc;
    srap_pkg::srap_acc_s exp_q[$];
    int failures = 0;
    int num_checks = 0;
    integer seed = 23;

    srap_host u_srap_host (.sys_clk(sys_clk), .cs_n(cs_n),
        .slave_addr_strobe_n(strobe_n), .slave_read_write(rw),
        .reg_addr_pin(addr));
    srap_port u_srap_port (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
        .slave_addr_strobe_n(strobe_n), .slave_read_write(rw),
        .reg_addr_pin(addr), .core_busy(core_busy),
        .master_active(master_active), .master_wait(master_wait),
        .slave_mem_ack_n(slave_mem_ack_n), .data_size_ack_pair_out(pair),
        .data_size_ack_pair_oe(oe), .reg_req(reg_req),
        .reg_req_acc(req_acc), .reg_latched_acc(lat_acc));

    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        $display("Checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Bounded wait; counts edges until the acknowledge goes low
    task automatic wait_ack(output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (slave_mem_ack_n !== 1'h0 && n < 20);
        if (n >= 20) begin
            failures++;
            test_done();
        end
    endtask

    task automatic check_idle(input int cyc, input logic [7:0] exp_oe);
        repeat (cyc) @(posedge sys_clk);
        #1;
        chk(8'(slave_mem_ack_n), 8'h01);
        chk(8'(pair), 8'h03);
        chk(8'(oe), exp_oe);
    endtask

    task automatic access(input logic busy, input int waits,
                          input logic keep, input logic csrel,
                          input int lat);
        srap_pkg::srap_acc_s a;
        int n;
        a.addr = srap_pkg::srap_addr_t'($random(seed));
        a.write = 1'($random(seed));
        u_srap_host.drive(1'h0, 1'h0, ~a.write, a.addr);
        core_busy <= busy;
        exp_q.push_back(a);
        fork
            wait_ack(n);
            if (waits > 0) begin
                repeat (3) @(posedge sys_clk);
                master_active <= 1'h1;
                master_wait <= 1'h1;
                repeat (waits) @(posedge sys_clk);
                master_active <= 1'h0;
                master_wait <= 1'h0;
            end
        join
        chk(8'(n), 8'(lat));
        chk(8'(pair), 8'h00);
        chk(8'(oe), 8'h01);
        chk(8'(reg_req), 8'h01);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(8'(slave_mem_ack_n), 8'h00);
        chk(8'(reg_req), 8'h00);
        if (csrel) begin
            u_srap_host.drop_cs();
            check_idle(3, 8'h01);
        end
        u_srap_host.finish(keep);
        check_idle(3, 8'h00);
        chk(8'(lat_acc), 8'(a));
        u_srap_host.scramble();
    endtask

    // Reference queue pairs each request with what the host sent
    // Sampled mid-cycle so the pulse and its access have settled
    always @(negedge sys_clk) begin
        if (reg_req === 1'h1) begin
            chk(8'(req_acc), 8'(exp_q.pop_front()));
        end
    end

    initial begin
        rst_n = 1'h0;
        core_busy = 1'h0;
        master_active = 1'h0;
        master_wait = 1'h0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge sys_clk);
        // two sync clocks in the delay
        for (int i = 0; i < 3; i++) begin
            access(1'h0, 0, 1'h0, 1'h0, 4);
        end
        access(1'h1, 0, 1'h0, 1'h0, 8);
        access(1'h1, 2, 1'h0, 1'h0, 10);
        access(1'h0, 0, 1'h1, 1'h0, 4);
        access(1'h0, 0, 1'h1, 1'h0, 3);
        access(1'h0, 0, 1'h0, 1'h0, 3);
        // Master without wait states, or a wait flag alone, adds no delay
        master_active <= 1'h1;
        access(1'h0, 0, 1'h0, 1'h0, 4);
        master_active <= 1'h0;
        master_wait <= 1'h1;
        access(1'h1, 0, 1'h0, 1'h0, 8);
        master_wait <= 1'h0;
        // Select arrives with strobe high: that strobe gets no ack
        u_srap_host.drive(1'h0, 1'h1, 1'h1, '0);
        check_idle(8, 8'h00);
        u_srap_host.drive(1'h0, 1'h0, 1'h1, '0);
        check_idle(8, 8'h00);
        u_srap_host.drive(1'h0, 1'h1, 1'h1, '0);
        repeat (4) @(posedge sys_clk);
        access(1'h0, 0, 1'h0, 1'h0, 3);
        access(1'h0, 0, 1'h0, 1'h1, 4);
        repeat (4) @(posedge sys_clk);
        test_done();
    end
endmodule
